// [include/lhc_pkg.sv]
// constants and helpers shared by the laser host command port
//--------------------------------------------------------------------
//--------------------------------------------------------------------
package lhc_pkg;

	//----------------------------------------------------------------
	// clock and timing
	//----------------------------------------------------------------
	localparam int CLK_HZ        = 10_000_000;         // core clock rate
	localparam int KEEPALIVE_MS  = 5000;               // keep-alive window
	localparam int KEEPALIVE_CYC = KEEPALIVE_MS * (CLK_HZ / 1000);
	localparam int KA_W          = 26;                 // keep-alive counter width
	localparam int DIV_W         = 17;                 // bit-time counter width

	//----------------------------------------------------------------
	// serial link and characters
	//----------------------------------------------------------------
	localparam logic [3:0] BAUD_SEL_RST = 4'h7;        // selects 9600
	localparam logic [7:0] CH_CR        = 8'h0D;       // carriage return
	localparam logic [7:0] CH_LF        = 8'h0A;       // line feed
	localparam logic [7:0] CH_ZERO      = 8'h30;       // ASCII '0'
	localparam logic [7:0] CH_TWO       = 8'h32;       // ASCII '2'
	localparam logic [7:0] CH_REMOTE    = 8'h52;       // mode: remote
	localparam logic [7:0] CH_LOCAL     = 8'h4C;       // mode: local

	//----------------------------------------------------------------
	// commands: code hi nibble 1..4, lo nibble 1..5
	//----------------------------------------------------------------
	localparam int         CMD_NUM    = 20;            // keypad commands
	localparam logic [7:0] Q_PARAMS   = 8'h03;         // program query
	localparam logic [7:0] Q_STATUS   = 8'h04;         // status query
	localparam int         CMD_REMLOC = 9;             // index of 023H
	localparam int         PAR_LEN    = 44;            // parameter reply bytes
	localparam int         STA_LEN    = 11;            // status reply bytes
	localparam int         RP_BITS    = PAR_LEN * 8;   // reply buffer width

	//----------------------------------------------------------------
	// reset values
	//----------------------------------------------------------------
	localparam logic [11:0] SYNC_RST   = 12'h800;      // line idles high
	localparam logic        REMOTE_RST = 1'b0;         // start in local

	// supported line rates by select code
	function automatic int baud_rate(input logic [3:0] sel);
		case (sel)
			4'h0:    baud_rate = 110;
			4'h1:    baud_rate = 150;
			4'h2:    baud_rate = 300;
			4'h3:    baud_rate = 600;
			4'h4:    baud_rate = 1200;
			4'h5:    baud_rate = 2400;
			4'h6:    baud_rate = 4800;
			4'h8:    baud_rate = 19200;
			default: baud_rate = 9600;
		endcase
	endfunction : baud_rate

	// ASCII digit for a flag
	function automatic logic [7:0] flag_ch(input logic b);
		flag_ch = CH_ZERO | {7'h00, b};
	endfunction : flag_ch

endpackage : lhc_pkg

// [src/lhc_fifo.sv]
// small reply FIFO between the reply builder and the transmitter
`timescale 1ns/10ps
module lhc_fifo #(
	parameter int W = 8,                   // word width
	parameter int D = 4                    // depth in words
) (
	input  wire logic         clk,         // core clock
	input  wire logic         rst_n,       // synchronised reset, low active
	input  wire logic         in_valid,    // word offered
	output logic              in_ready,    // room for a word
	input  wire logic [W-1:0] in_data,     // word in
	output logic              out_valid,   // word available
	input  wire logic         out_ready,   // reader takes the word
	output logic [W-1:0]      out_data     // word out
);
	import lhc_pkg::*;

	localparam int AW = $clog2(D);

	//----------------------------------------------------------------
	// state
	//----------------------------------------------------------------
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;          // storage
		logic [AW-1:0]       wp;           // write pointer
		logic [AW-1:0]       rp;           // read pointer
		logic [AW:0]         cnt;          // words held
	} lhc_fifo_st_t;

	lhc_fifo_st_t r;                        // registered state
	lhc_fifo_st_t next_r;                   // next state

	// honest flags from the fill count
	assign in_ready  = (r.cnt != (AW+1)'(D));
	assign out_valid = (r.cnt != '0);
	assign out_data  = r.mem[r.rp];

	// pointer and count update
	always_comb
	begin
		logic wr;
		logic rd;
		wr     = in_valid && in_ready;
		rd     = out_valid && out_ready;
		next_r = r;
		if (wr)
		begin
			next_r.mem[r.wp] = in_data;
			next_r.wp        = (r.wp == AW'(D-1)) ? '0 : r.wp + 1'b1;
		end
		if (rd)
			next_r.rp = (r.rp == AW'(D-1)) ? '0 : r.rp + 1'b1;
		if (wr && !rd)
			next_r.cnt = r.cnt + 1'b1;
		else if (rd && !wr)
			next_r.cnt = r.cnt - 1'b1;
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

endmodule : lhc_fifo

// [src/lhc_top.sv]
// serial command interpreter of the laser control unit
`timescale 1ns/10ps
module lhc_top #(
	parameter int CLK_FREQ = lhc_pkg::CLK_HZ,        // core clock in Hz
	parameter int KA_CYC   = lhc_pkg::KEEPALIVE_CYC  // keep-alive window
) (
	input  wire logic        CORE_CLK,               // 10 MHz core clock
	input  wire logic        RESET_N,                // power-up reset, low
	input  wire logic        RXD,                    // serial in from host
	output logic             TXD,                    // serial out to host
	input  wire logic [3:0]  BAUD_SEL,               // line rate select
	input  wire logic        KEYPAD_PRESENT,         // remote keypad seen
	input  wire logic        SHUTTER_OPEN,           // shutter is open
	input  wire logic        QSW_ACTIVE,             // Q-switch active
	input  wire logic [3:0]  EOC,                    // banks 4..1 charged
	input  wire logic [3:0]  HG_LIMIT,               // h1cw,h1ccw,h2cw,h2ccw
	input  wire logic [31:0] REP_RATE_TXT,           // 4 ASCII chars
	input  wire logic [31:0] QSW_DELAY_TXT,          // 4 ASCII chars
	input  wire logic [31:0] PULSE_DIV_TXT,          // 4 ASCII chars
	input  wire logic [63:0] SHOT_TXT,               // 8 ASCII chars
	input  wire logic [39:0] BAUD_TXT,               // 5 ASCII chars
	input  wire logic [7:0]  ACT_PARAM_TXT,          // active parameter
	input  wire logic [7:0]  LAST_PU_TXT,            // last power_unit
	input  wire logic        TWO_PU,                 // two power_units fitted
	output logic [19:0]      CMD_PULSE,              // one-hot key commands
	output logic             REMOTE_MODE,            // remote control mode
	output logic             HOST_ACTIVE,            // host in control
	output logic             KEYPAD_ACTIVE,          // keypad in control
	output logic             WARM_RESET,             // enter warm reset
	output logic             ECHO_VALID,             // byte for keypad display
	output logic [7:0]       ECHO_BYTE               // echoed command byte
);
	import lhc_pkg::*;

	//----------------------------------------------------------------
	// types and state
	//----------------------------------------------------------------
	typedef enum logic [4:0] {
		HUNT_HOST = 5'h01,                  // power-up: wait for host
		HUNT_PAD  = 5'h02,                  // then wait for keypad
		CTL_HOST  = 5'h04,                  // host in control
		CTL_PAD   = 5'h08,                  // keypad in control
		WARM      = 5'h10                   // timed out or keypad lost, warm reset
	} lhc_hunt_t;

	typedef enum logic [1:0] {
		RP_IDLE = 2'h1,                     // no reply in flight
		RP_SEND = 2'h2                      // pushing reply bytes
	} lhc_reply_t;

	typedef struct packed {
		lhc_hunt_t          hunt;           // controller state
		logic [KA_W-1:0]    ka;             // keep-alive timer
		logic [11:0]        sy1;            // pin sync stage one
		logic [11:0]        sy2;            // pin sync stage two
		logic               rx_on;          // receiving a frame
		logic [DIV_W-1:0]   rx_cnt;         // receive bit timer
		logic [3:0]         rx_bit;         // receive bit number
		logic [7:0]         rx_sh;          // receive shifter
		logic               tx_on;          // sending a frame
		logic [DIV_W-1:0]   tx_cnt;         // send bit timer
		logic [3:0]         tx_bit;         // send bit number
		logic [9:0]         tx_sh;          // send shifter
		logic               txd;            // line level
		lhc_reply_t         rp;             // reply state
		logic               pq_par;         // parameter query pending
		logic               pq_sta;         // status query pending
		logic [RP_BITS-1:0] rp_buf;         // reply bytes, first on top
		logic [5:0]         rp_left;        // reply bytes still to push
		logic               remote;         // remote/local mode
		logic [19:0]        cmd;            // command pulses
		logic               warm;           // warm reset pulse
		logic               echo_v;         // echo pulse
		logic [7:0]         echo_b;         // echo data
	} lhc_st_t;

	lhc_st_t          r;                    // registered state
	lhc_st_t          next_r;               // next state
	logic [1:0]       rst_sy;               // reset release chain
	logic             rst_n;                // synchronised reset
	logic             f_in_ready;           // fifo has room
	logic             f_out_valid;          // fifo has a byte
	logic [7:0]       f_out_data;           // byte to send
	logic             f_in_valid;           // reply byte offered
	logic             tx_take;              // transmitter takes a byte
	logic [DIV_W-1:0] div;                  // cycles per bit

	//----------------------------------------------------------------
	// helpers
	//----------------------------------------------------------------
	// cycles per bit for the selected line rate
	function automatic logic [DIV_W-1:0] bit_div(input logic [3:0] sel);
		bit_div = DIV_W'(CLK_FREQ / baud_rate(sel));
	endfunction : bit_div

	// command index: valid for hi 1..4 and lo 1..5
	function automatic logic [5:0] cmd_idx(input logic [7:0] b);
		logic [2:0] hi;
		logic [2:0] lo;
		hi = b[6:4] - 3'h1;
		lo = b[2:0] - 3'h1;
		if (b[7] || b[6:4] == 3'h0 || b[6:4] > 3'h4 || b[3] ||
		    b[2:0] == 3'h0 || b[2:0] > 3'h5)
			cmd_idx = 6'h3F;
		else
			cmd_idx = {1'b0, lo, 2'h0} + {3'h0, hi};
	endfunction : cmd_idx

	//----------------------------------------------------------------
	// reset release
	//----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
			rst_sy <= 2'h0;
		else
			rst_sy <= {rst_sy[0], 1'b1};
	end
	assign rst_n = rst_sy[1];

	//----------------------------------------------------------------
	// reply fifo
	//----------------------------------------------------------------
	lhc_fifo #(
		.W(8),
		.D(4)
	) u_fifo (
		.clk       (CORE_CLK),
		.rst_n     (rst_n),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (r.rp_buf[RP_BITS-1 -: 8]),
		.out_valid (f_out_valid),
		.out_ready (tx_take),
		.out_data  (f_out_data)
	);

	assign f_in_valid = (r.rp == RP_SEND);
	assign tx_take    = !r.tx_on;
	assign div        = bit_div(BAUD_SEL);

	//----------------------------------------------------------------
	// next state
	//----------------------------------------------------------------
	always_comb
	begin
		logic       rxd;
		logic       got;
		logic [5:0] ci;
		logic       ka_out;
		logic       kp;
		rxd    = r.sy2[11];
		kp     = r.sy2[10];
		got    = 1'b0;
		ci     = cmd_idx(r.rx_sh);
		ka_out = (r.ka == KA_W'(KA_CYC - 1));
		next_r = r;
		next_r.sy1    = {RXD, KEYPAD_PRESENT, SHUTTER_OPEN, QSW_ACTIVE,
		                 EOC, HG_LIMIT};
		next_r.sy2    = r.sy1;
		next_r.cmd    = '0;
		next_r.warm   = 1'b0;
		next_r.echo_v = 1'b0;

		// receiver: start, 8 data lsb first, stop
		if (!r.rx_on)
		begin
			if (!rxd)
			begin
				next_r.rx_on  = 1'b1;
				next_r.rx_cnt = div >> 1;
				next_r.rx_bit = 4'h0;
			end
		end
		else if (r.rx_cnt != '0)
			next_r.rx_cnt = r.rx_cnt - 1'b1;
		else
		begin
			next_r.rx_cnt = div - 1'b1;
			next_r.rx_bit = r.rx_bit + 1'b1;
			if (r.rx_bit == 4'h0 && rxd)
				next_r.rx_on = 1'b0;        // glitch, not a start bit
			else if (r.rx_bit == 4'h9)
			begin
				next_r.rx_on = 1'b0;
				got          = rxd;         // framing error drops byte
			end
			else if (r.rx_bit != 4'h0)
				next_r.rx_sh = {rxd, r.rx_sh[7:1]};
		end

		// command decode; unknown codes raise no key pulse but still keep the link alive, and are echoed only in CTL_HOST with a keypad present
		if (got)
		begin
			if (ci != 6'h3F)
				next_r.cmd[ci[4:0]] = 1'b1;
			if (ci == 6'(CMD_REMLOC))
				next_r.remote = !r.remote;
			if (r.hunt == CTL_HOST && kp)
			begin
				next_r.echo_v = 1'b1;
				next_r.echo_b = r.rx_sh;
			end
		end

		// controller hunt and keep-alive timer
		next_r.ka = r.ka + 1'b1;
		case (r.hunt)
			HUNT_HOST:
			begin
				if (got)
					next_r.hunt = CTL_HOST;
				else if (ka_out)
					next_r.hunt = HUNT_PAD;
			end
			HUNT_PAD:
			begin
				if (got)
					next_r.hunt = CTL_HOST;
				else if (kp)
					next_r.hunt = CTL_PAD;
				else if (ka_out)
				begin
					next_r.hunt = WARM;
					next_r.warm = 1'b1;
				end
			end
			CTL_HOST:
			begin
				if (got)
					next_r.ka = '0;
				else if (ka_out)
				begin
					next_r.hunt = WARM;
					next_r.warm = 1'b1;
				end
			end
			CTL_PAD:
			begin
				if (got)
					next_r.hunt = CTL_HOST;                 // host takes over
				else if (!kp)
				begin
					next_r.hunt = WARM;
					next_r.warm = 1'b1;
				end
			end
			WARM:
			begin
				if (got)
					next_r.hunt = CTL_HOST;
				else if (kp)
					next_r.hunt = CTL_PAD;
			end
			default:
				next_r.hunt = HUNT_HOST;
		endcase
		if (next_r.hunt != r.hunt)
			next_r.ka = '0;

		// reply engine: one reply at a time, parameters first
		case (r.rp)
			RP_IDLE:
			begin
				if (r.pq_par)
				begin
					next_r.pq_par  = 1'b0;
					next_r.rp      = RP_SEND;
					next_r.rp_left = 6'(PAR_LEN);
					next_r.rp_buf  = {
						REP_RATE_TXT,  CH_CR, CH_LF,
						QSW_DELAY_TXT, CH_CR, CH_LF,
						PULSE_DIV_TXT, CH_CR, CH_LF,
						SHOT_TXT,      CH_CR, CH_LF,
						BAUD_TXT,      CH_CR, CH_LF,
						ACT_PARAM_TXT, CH_CR, CH_LF,
						(TWO_PU ? CH_TWO : LAST_PU_TXT),
						CH_CR, CH_LF,
						(r.remote ? CH_REMOTE : CH_LOCAL),
						CH_CR, CH_LF};
				end
				else if (r.pq_sta)
				begin
					next_r.pq_sta  = 1'b0;
					next_r.rp      = RP_SEND;
					next_r.rp_left = 6'(STA_LEN);
					next_r.rp_buf  = {
						flag_ch(r.sy2[8]),
						flag_ch(r.sy2[3]), flag_ch(r.sy2[2]),
						flag_ch(r.sy2[1]), flag_ch(r.sy2[0]),
						flag_ch(r.sy2[4]), flag_ch(r.sy2[5]),
						flag_ch(r.sy2[6]), flag_ch(r.sy2[7]),
						flag_ch(r.sy2[9]),
						CH_CR,
						(RP_BITS - STA_LEN * 8)'(0)};
				end
			end
			RP_SEND:
			begin
				if (f_in_ready)
				begin
					next_r.rp_buf  = {r.rp_buf[RP_BITS-9:0], 8'h00};
					next_r.rp_left = r.rp_left - 1'b1;
					if (r.rp_left == 6'h01)
						next_r.rp = RP_IDLE;
				end
			end
			default:
				next_r.rp = RP_IDLE;
		endcase

		// queries pend until the engine is free; set wins over clear
		if (got && r.rx_sh == Q_PARAMS)
			next_r.pq_par = 1'b1;
		if (got && r.rx_sh == Q_STATUS)
			next_r.pq_sta = 1'b1;

		// transmitter: start, 8 data lsb first, stop
		if (!r.tx_on)
		begin
			if (f_out_valid)
			begin
				next_r.tx_on  = 1'b1;
				next_r.tx_sh  = {1'b1, f_out_data, 1'b0};
				next_r.tx_bit = 4'h0;
				next_r.tx_cnt = div - 1'b1;
				next_r.txd    = 1'b0;
			end
		end
		else if (r.tx_cnt != '0)
			next_r.tx_cnt = r.tx_cnt - 1'b1;
		else if (r.tx_bit == 4'h9)
		begin
			next_r.tx_on = 1'b0;
			next_r.txd   = 1'b1;
		end
		else
		begin
			next_r.tx_sh  = {1'b1, r.tx_sh[9:1]};
			next_r.txd    = r.tx_sh[1];
			next_r.tx_bit = r.tx_bit + 1'b1;
			next_r.tx_cnt = div - 1'b1;
		end
	end

	//----------------------------------------------------------------
	// state register
	//----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			r        <= '0;
			r.hunt   <= HUNT_HOST;
			r.rp     <= RP_IDLE;
			r.sy1    <= SYNC_RST;
			r.sy2    <= SYNC_RST;
			r.txd    <= 1'b1;
			r.remote <= REMOTE_RST;
		end
		else
			r <= next_r;
	end

	//----------------------------------------------------------------
	// outputs, all from flops
	//----------------------------------------------------------------
	assign TXD           = r.txd;
	assign CMD_PULSE     = r.cmd;
	assign REMOTE_MODE   = r.remote;
	assign HOST_ACTIVE   = r.hunt[2];
	assign KEYPAD_ACTIVE = r.hunt[3];
	assign WARM_RESET    = r.warm;
	assign ECHO_VALID    = r.echo_v;
	assign ECHO_BYTE     = r.echo_b;

endmodule : lhc_top

// [verif/lhc_assertions.sv]
// pin-level checks of the host command port
`timescale 1ns/10ps
module lhc_checker #(
	parameter int KA_CYC = 25000          // keep-alive window
) (
	input wire logic        CORE_CLK,       // core clock
	input wire logic        RESET_N,        // reset, low
	input wire logic        RXD,            // serial in
	input wire logic        TXD,            // serial out
	input wire logic [19:0] CMD_PULSE,      // key pulses
	input wire logic        REMOTE_MODE,    // remote mode
	input wire logic        HOST_ACTIVE,    // host state
	input wire logic        KEYPAD_ACTIVE,  // keypad state
	input wire logic        WARM_RESET,     // warm pulse
	input wire logic        ECHO_VALID      // echo pulse
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	logic [31:0] idle;                      // cycles since input was low
	// ----------------------------------------
	// helper: silence on the serial input
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge RESET_N)
		if (!RESET_N)
			idle <= 32'h0;
		else if (!RXD)
			idle <= 32'h0;
		else
			idle <= idle + 32'h1;
	sequence s_start; $fell(TXD); endsequence
	sequence s_low; !TXD [*8]; endsequence
	property p_start; s_start |-> s_low; endproperty
	property p_hot; $onehot0(CMD_PULSE); endproperty
	property p_pulse; |CMD_PULSE |=> CMD_PULSE == 20'h0; endproperty
	property p_remloc; $changed(REMOTE_MODE) |-> CMD_PULSE[9] || $past(CMD_PULSE[9]); endproperty
	property p_warm; WARM_RESET |=> !WARM_RESET; endproperty
	property p_wstate; WARM_RESET |-> ##[0:1] !HOST_ACTIVE; endproperty
	property p_ka; WARM_RESET && $past(HOST_ACTIVE) |-> idle >= KA_CYC; endproperty
	property p_excl; !(HOST_ACTIVE && KEYPAD_ACTIVE); endproperty
	property p_echo; ECHO_VALID |-> ##[0:1] HOST_ACTIVE; endproperty
	a_start: assert property (p_start) else $error("short start bit");
	a_hot: assert property (p_hot) else $error("two key pulses");
	a_pulse: assert property (p_pulse) else $error("key pulse too long");
	a_remloc: assert property (p_remloc) else $error("mode moved alone");
	a_warm: assert property (p_warm) else $error("warm pulse too long");
	a_wstate: assert property (p_wstate) else $error("host kept in warm");
	a_ka: assert property (p_ka) else $error("warm reset too early");
	a_excl: assert property (p_excl) else $error("two controllers");
	a_echo: assert property (p_echo) else $error("echo without host");
endmodule : lhc_checker
bind lhc_top lhc_checker #(.KA_CYC(KA_CYC)) u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
	.RXD(RXD), .TXD(TXD), .CMD_PULSE(CMD_PULSE), .REMOTE_MODE(REMOTE_MODE),
	.HOST_ACTIVE(HOST_ACTIVE), .KEYPAD_ACTIVE(KEYPAD_ACTIVE), .WARM_RESET(WARM_RESET),
	.ECHO_VALID(ECHO_VALID));

// [verif/lhc_host_model.sv]
// serial host model: sends command bytes, collects reply bytes
`timescale 1ns/10ps
module lhc_host_model #(
	parameter int DIV = 26     // cycles per bit
) (
	input  wire logic clk,     // core clock
	output logic      rxd,     // unit serial input
	input  wire logic txd      // unit serial output
);
	logic [7:0] rx_q [$];      // reply bytes in order
	logic [7:0] sh;            // receive shift
	initial rxd = 1'b1;
	// one frame, lsb first; any byte keeps the link alive
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			rxd <= fr[i];
			repeat (DIV) @(posedge clk);
		end
	endtask : send_byte
	// mid-bit sampling of each reply frame
	always
	begin
		@(negedge txd);
		repeat (DIV / 2) @(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (DIV) @(posedge clk);
			sh[i] = txd;
		end
		repeat (DIV) @(posedge clk);
		rx_q.push_back(sh);
	end
endmodule : lhc_host_model

// [verif/laser_host_command_port_tb_top.sv]
// self-checking bench of the host command port
`timescale 1ns/10ps
module laser_host_command_port_tb_top;
	import lhc_pkg::*;
	localparam int CF    = 500000;      // shortened core rate
	localparam int KA    = 25000;       // shortened keep-alive window
	localparam int DIV   = CF / 19200;  // bit time at select 8
	localparam int LIMIT = 80000;       // run ceiling
	logic        clk = 1'b0;            // core clock
	logic        rst_n, rxd, txd, kp, shut, qsw, two_pu;
	logic [3:0]  baud, eoc, hgl;
	logic [31:0] rate, dly, pdiv;
	logic [63:0] shot;
	logic [39:0] btxt;
	logic [7:0]  act, lpu, echo_byte, last_echo;
	logic [19:0] cmd, last_cmd;
	logic        remote, host_act, kp_act, warm, echo_v;
	int          miscompares = 0, checked = 0, cyc = 0, pulses = 0, warms = 0;
	always #50 clk = ~clk;
	lhc_host_model #(.DIV(DIV)) host (.clk(clk), .rxd(rxd), .txd(txd));
	lhc_top #(.CLK_FREQ(CF), .KA_CYC(KA)) DUT (.CORE_CLK(clk), .RESET_N(rst_n), .RXD(rxd),
		.TXD(txd), .BAUD_SEL(baud), .KEYPAD_PRESENT(kp), .SHUTTER_OPEN(shut),
		.QSW_ACTIVE(qsw), .EOC(eoc), .HG_LIMIT(hgl), .REP_RATE_TXT(rate), .QSW_DELAY_TXT(dly),
		.PULSE_DIV_TXT(pdiv), .SHOT_TXT(shot), .BAUD_TXT(btxt), .ACT_PARAM_TXT(act),
		.LAST_PU_TXT(lpu), .TWO_PU(two_pu), .CMD_PULSE(cmd), .REMOTE_MODE(remote),
		.HOST_ACTIVE(host_act), .KEYPAD_ACTIVE(kp_act), .WARM_RESET(warm),
		.ECHO_VALID(echo_v), .ECHO_BYTE(echo_byte));
	// captures one-cycle pulses and cuts a hang short
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cmd != 20'h0)
			last_cmd <= cmd;
		if (cmd != 20'h0)
			pulses <= pulses + 1;
		if (echo_v === 1'b1)
			last_echo <= echo_byte;
		if (warm === 1'b1)
			warms <= warms + 1;
		if (cyc == LIMIT)
		begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic cmp_bit(input logic g, input logic e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t flag %b exp %b", $time, g, e);
		end
	endtask : cmp_bit
	task automatic cmp_vec(input logic [19:0] g, input logic [19:0] e);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t value %h exp %h", $time, g, e);
		end
	endtask : cmp_vec
	task automatic get_byte(output logic [7:0] b);
		for (int i = 0; i < 20 * DIV && host.rx_q.size() == 0; i++)
			@(posedge clk);
		b = (host.rx_q.size() > 0) ? host.rx_q.pop_front() : 8'hXX;
	endtask : get_byte
	task automatic t_reset;
		cmp_bit(txd, 1'b1);
		cmp_vec(cmd, 20'h0);
		cmp_bit(remote, 1'b0);
		cmp_bit(host_act, 1'b0);
	endtask : t_reset
	// a keep-alive byte takes control, then every key code, then the mode toggle
	task automatic t_cmds;
		logic [7:0] c [20];
		int         x [20];
		c = '{8'h11, 8'h21, 8'h31, 8'h41, 8'h12, 8'h22, 8'h32, 8'h42, 8'h13, 8'h33,
			8'h43, 8'h14, 8'h24, 8'h34, 8'h44, 8'h15, 8'h25, 8'h35, 8'h45, 8'h23};
		x = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 9};
		host.send_byte(8'h00);
		repeat (8) @(posedge clk);
		cmp_bit(host_act, 1'b1);
		for (int i = 0; i < 20; i++)
		begin
			host.send_byte(c[i]);
			repeat (8) @(posedge clk);
			cmp_vec(last_cmd, 20'h1 << x[i]);
			cmp_vec({12'h0, last_echo}, {12'h0, c[i]});
		end
		cmp_bit(host_act, 1'b1);
		cmp_bit(remote, 1'b1);
	endtask : t_cmds
	// both queries back to back: parameters whole, then status
	task automatic t_replies;
		logic [439:0] e;
		logic [7:0]   b;
		@(posedge clk);
		qsw <= 1'b0;
		shut <= 1'b1;
		eoc <= 4'h5;
		hgl <= 4'h9;
		two_pu <= 1'b1;
		repeat (4) @(posedge clk);
		e = {rate, 16'h0D0A, dly, 16'h0D0A, pdiv, 16'h0D0A, shot, 16'h0D0A, btxt, 16'h0D0A,
			act, 16'h0D0A, 24'h320D0A, 24'h520D0A, 80'h30313030313130313031, 8'h0D};
		host.send_byte(Q_PARAMS);
		host.send_byte(Q_STATUS);
		for (int k = 0; k < 55; k++)
		begin
			get_byte(b);
			cmp_vec({12'h0, b}, {12'h0, e[439 - 8 * k -: 8]});
		end
	endtask : t_replies
	// stray byte, then silence until the warm state
	task automatic t_warm;
		int n, t;
		n = pulses;
		host.send_byte(8'h77);
		t = cyc;
		repeat (8) @(posedge clk);
		cmp_vec(20'(pulses - n), 20'h0);
		cmp_bit(host_act, 1'b1);
		for (int i = 0; i < KA + 500 && warms == 0; i++)
			@(posedge clk);
		cmp_bit(cyc - t > KA - 60 && cyc - t < KA + 60, 1'b1);
		cmp_bit(host_act, 1'b0);
		repeat (8) @(posedge clk);
		cmp_bit(kp_act, 1'b1);
	endtask : t_warm
	task automatic wrap_up;
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial
	begin
		{rst_n, shut, two_pu, eoc, hgl} = '0;
		{kp, qsw, baud, act, lpu} = {2'h3, 4'h8, 8'h31, 8'h31};
		{rate, dly, pdiv} = {32'h31302E30, 32'h30323030, 32'h30303031};
		{shot, btxt} = {64'h3030303031323334, 40'h3139323030};
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		t_reset();
		t_cmds();
		t_replies();
		t_warm();
		wrap_up();
	end
endmodule : laser_host_command_port_tb_top
